// *** include/ccl_pkg.sv ***
// Constants shared by the charger control logic
// What this block does
// [RL1] Unlock pin low: safety limits stay at defaults, host writes ignored.
// [RL2] Unlock pin high: limits writable until a write to another register locks them.
// [RL3] Inhibit pin low enables charge; high disables and releases both inputs.
// [RL4] Long-timer mode: inhibit high restarts the fifteen-minute safety timer.
// [RL5] Short-timer mode: inhibit high leaves the 32-second timer running.
// [RL6] Active boost pin with function enabled forces boost, over host command.
// [RL7] A control bit picks which pin level counts as boost-active.
// [RL8] After reset the boost pin picks input cap: high 500mA, low 100mA.
// [RL9] Indicator pulled low while charging, released otherwise without fault.
// [RL10] A fault gives one 128 microsecond low pulse on the indicator.
// [RL11] Indicator enable bit cleared stops driving the indicator.
// [RL12] Charge runs conditioning, then constant current, then constant voltage.
// [RL13] Charging ends when current falls to termination level, if enabled.
// [RL14] Safety timer with host reset backs up lost supervision.
// [RL15] Battery below recharge threshold starts a new cycle automatically.
// [RL16] Losing input supply moves the block to sleep or high impedance.
// [RL17] Hot junction while charging reduces the charge current.
// [RL18] Charge status is readable by the host.
// [RL19] Input current is capped at the host-programmed limit.
// [RL20] Host sets lamp current and on and off times for blink modes.
// [RL21] Safety limits arrive as parallel register write pulses (regWrStb, regWrData), other parameters as input ports, not from a serial host link.
// [RL22] Inhibit, unlock and boost pins pass two flip-flops first.
// [RL23] Fault pulse timed by a counter, not retriggered while running.
package ccl_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned FAULT_PULSE_US  = 128;
    localparam int unsigned FAULT_PULSE_CYC = FAULT_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned LONG_TIMER_S    = 900;
    localparam int unsigned SHORT_TIMER_S   = 32;
    localparam longint unsigned LONG_TIMER_CYC  = 64'(LONG_TIMER_S) * CLK_HZ;
    localparam longint unsigned SHORT_TIMER_CYC = 64'(SHORT_TIMER_S) * CLK_HZ;
    localparam int unsigned LAMP_MS_CYC     = CLK_HZ / 1000;
    localparam logic [7:0] SAFE_LIMIT_RST   = 8'h00;
    localparam logic [1:0] CAP_100MA        = 2'h0;
    localparam logic [1:0] CAP_500MA        = 2'h1;
    typedef enum logic [4:0] {
        CCL_IDLE  = 5'h01,
        CCL_COND  = 5'h02,
        CCL_CC    = 5'h04,
        CCL_CV    = 5'h08,
        CCL_DONE  = 5'h10
    } ccl_state_t;
endpackage : ccl_pkg

// *** src/ccl_sync.sv ***
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/100ps
module ccl_sync
    import ccl_pkg::*;
(
    input  wire logic sys_clk, // System clock
    input  wire logic rst,     // Async reset
    input  wire logic asyncIn, // Pin level
    output logic      syncOut  // Synchronised level
);
    logic meta_ff;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_ff <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            meta_ff <= asyncIn; // RL22
            syncOut <= meta_ff;
        end
    end
endmodule : ccl_sync

// *** src/ccl_charger_ctrl.sv ***
// Charger control sequencing, pins and status
`timescale 1ns/100ps
module ccl_charger_ctrl
    import ccl_pkg::*;
#(
    parameter longint unsigned LONG_CYC  = LONG_TIMER_CYC,  // Long safety timeout
    parameter longint unsigned SHORT_CYC = SHORT_TIMER_CYC  // Short safety timeout
)(
    input  wire logic       sys_clk,        // 100 MHz clock
    input  wire logic       rst,            // Async reset
    input  wire logic       inhibitPin,     // Charge inhibit pin
    input  wire logic       unlockPin,      // Safety limit unlock pin
    input  wire logic       boostPin,       // Boost request pin
    input  wire logic       regWrStb,       // Host register write pulse
    input  wire logic       regWrSafe,      // Write targets safety limits
    input  wire logic [7:0] regWrData,      // Safety limit data
    input  wire logic       boostFnEn,      // Boost pin function enable
    input  wire logic       boostActHigh,   // Boost pin polarity
    input  wire logic       boostHostCmd,   // Host boost command
    input  wire logic       ctrlConfigured, // Control settings valid after reset
    input  wire logic [1:0] hostCap,        // Host input current cap
    input  wire logic       termEn,         // Termination enable
    input  wire logic       longMode,       // 1 long timer, 0 short timer
    input  wire logic       timerKick,      // Host safety timer reset pulse
    input  wire logic       statEn,         // Indicator enable
    input  wire logic [1:0] lampLevel,      // Lamp current code
    input  wire logic [7:0] lampOnMs,       // Lamp on time, ms
    input  wire logic [7:0] lampOffMs,      // Lamp off time, ms
    input  wire logic       supplyOk,       // Input supply present
    input  wire logic       battAboveShort, // Battery above conditioning level
    input  wire logic       battAtReg,      // Battery at regulation voltage
    input  wire logic       currAtTerm,     // Current at termination level
    input  wire logic       battBelowRch,   // Battery below recharge level
    input  wire logic       tjHot,          // Junction at thermal limit
    input  wire logic       faultIn,        // Fault event pulse
    output logic            statOe_n,       // Indicator drive, low pulls pin
    output logic            statOut,        // Indicator output level
    output logic            inputsHiZ_ff,   // Charger inputs high impedance
    output logic            sleep_ff,       // Sleep mode
    output logic            boostMode_ff,   // Bus converter in boost
    output logic [1:0]      inCap_ff,       // Input current cap code
    output logic [7:0]      safeLimit_ff,   // Effective safety limit
    output logic            chargeRed_ff,   // Thermal current reduction
    output logic [4:0]      chgStatus_ff,   // Charge state for host read
    output logic            timerFault_ff,  // Safety timer expired
    output logic [1:0]      lampDrive_ff    // Lamp current code driven
);
    // ************************
    // Pin synchronisers
    // ************************
    logic inhSync;
    logic unlSync;
    logic bstSync;
    ccl_sync uInh (.sys_clk(sys_clk), .rst(rst), .asyncIn(inhibitPin), .syncOut(inhSync));
    ccl_sync uUnl (.sys_clk(sys_clk), .rst(rst), .asyncIn(unlockPin), .syncOut(unlSync));
    ccl_sync uBst (.sys_clk(sys_clk), .rst(rst), .asyncIn(boostPin), .syncOut(bstSync));

    // ************************
    // Safety limit lock
    // ************************
    logic locked_ff;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            safeLimit_ff <= SAFE_LIMIT_RST;
            locked_ff    <= 1'b0;
        end else if (!unlSync) begin
            safeLimit_ff <= SAFE_LIMIT_RST; // RL1
            locked_ff    <= 1'b0;
        end else if (regWrStb && !regWrSafe) begin
            locked_ff <= 1'b1; // RL2
        end else if (regWrStb && regWrSafe && !locked_ff) begin
            safeLimit_ff <= regWrData; // RL2
        end
    end

    // ************************
    // Boost and input cap
    // ************************
    logic bstActive;
    assign bstActive = (bstSync == boostActHigh);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            boostMode_ff <= 1'b0;
            inCap_ff     <= CAP_100MA;
        end else if (!ctrlConfigured) begin
            boostMode_ff <= 1'b0;
            inCap_ff     <= bstSync ? CAP_500MA : CAP_100MA; // RL8
        end else begin
            boostMode_ff <= (boostFnEn && bstActive) ? 1'b1 : boostHostCmd; // RL6 RL7
            inCap_ff     <= hostCap; // RL19
        end
    end

    // ************************
    // Safety timer
    // ************************
    logic [37:0] tmr_ff;
    logic [37:0] tmrLimit;
    assign tmrLimit = longMode ? 38'(LONG_CYC) : 38'(SHORT_CYC);
    logic charging;
    ccl_state_t state_ff;
    assign charging = (state_ff == CCL_COND) || (state_ff == CCL_CC) || (state_ff == CCL_CV);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tmr_ff        <= 38'h0;
            timerFault_ff <= 1'b0;
        end else begin
            if (timerKick || (longMode && inhSync)) begin
                tmr_ff <= 38'h0; // RL14 RL4
            end else if (tmr_ff >= tmrLimit - 38'h1) begin
                tmr_ff <= 38'h0;
                if (charging) begin
                    timerFault_ff <= 1'b1; // RL14
                end
            end else begin
                tmr_ff <= tmr_ff + 38'h1; // RL5
            end
            if (timerKick) begin
                timerFault_ff <= 1'b0;
            end
        end
    end

    // ************************
    // Charge sequencer
    // ************************
    logic enable;
    assign enable = supplyOk && !inhSync && !timerFault_ff;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff <= CCL_IDLE;
        end else if (!enable) begin
            state_ff <= CCL_IDLE; // RL3 RL16
        end else begin
            unique case (state_ff)
                CCL_IDLE: state_ff <= CCL_COND;
                CCL_COND: if (battAboveShort) state_ff <= CCL_CC; // RL12
                CCL_CC:   if (battAtReg) state_ff <= CCL_CV; // RL12
                CCL_CV:   if (termEn && currAtTerm) state_ff <= CCL_DONE; // RL13
                CCL_DONE: if (battBelowRch) state_ff <= CCL_COND; // RL15
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            inputsHiZ_ff <= 1'b0;
            sleep_ff     <= 1'b0;
            chargeRed_ff <= 1'b0;
            chgStatus_ff <= CCL_IDLE;
        end else begin
            inputsHiZ_ff <= inhSync || !supplyOk; // RL3 RL16
            sleep_ff     <= !supplyOk; // RL16
            chargeRed_ff <= charging && tjHot; // RL17
            chgStatus_ff <= state_ff; // RL18
        end
    end

    // ************************
    // Fault pulse and indicator
    // ************************
    logic [14:0] pulse_ff;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pulse_ff <= 15'h0;
        end else if (pulse_ff != 15'h0) begin
            pulse_ff <= pulse_ff - 15'h1; // RL23
        end else if (faultIn) begin
            pulse_ff <= 15'(FAULT_PULSE_CYC); // RL10
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            statOe_n <= 1'b1;
            statOut  <= 1'b0;
        end else begin
            statOut  <= 1'b0;
            statOe_n <= !(statEn && (charging || pulse_ff != 15'h0)); // RL9 RL10 RL11
        end
    end

    // ************************
    // Lamp blink
    // ************************
    logic [16:0] msDiv_ff;
    logic [7:0]  msCnt_ff;
    logic        lampOn_ff;
    logic        msTick;
    assign msTick = (msDiv_ff == 17'(LAMP_MS_CYC - 1));
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            msDiv_ff     <= 17'h0;
            msCnt_ff     <= 8'h0;
            lampOn_ff    <= 1'b0;
            lampDrive_ff <= 2'h0;
        end else begin
            msDiv_ff <= msTick ? 17'h0 : msDiv_ff + 17'h1;
            if (msTick) begin
                if (msCnt_ff >= (lampOn_ff ? lampOnMs : lampOffMs)) begin
                    msCnt_ff  <= 8'h0;
                    lampOn_ff <= (lampOffMs == 8'h0) || !lampOn_ff; // RL20
                end else begin
                    msCnt_ff <= msCnt_ff + 8'h1;
                end
            end
            lampDrive_ff <= lampOn_ff && (lampOnMs != 8'h0) ? lampLevel : 2'h0; // RL20
        end
    end

    // ************************
    // Checks
    // ************************
    a_limit_default: assert property (@(posedge sys_clk) disable iff (rst)
        !unlSync |=> safeLimit_ff == SAFE_LIMIT_RST) else $error("limit not default"); // RL1
    a_limit_locked: assert property (@(posedge sys_clk) disable iff (rst)
        locked_ff && unlSync |=> $stable(safeLimit_ff)) else $error("locked limit moved"); // RL2
    a_inhibit_stop: assert property (@(posedge sys_clk) disable iff (rst)
        inhSync |=> state_ff == CCL_IDLE && inputsHiZ_ff) else $error("inhibit ignored"); // RL3
    a_long_restart: assert property (@(posedge sys_clk) disable iff (rst)
        longMode && inhSync |=> tmr_ff == 38'h0) else $error("timer not reset"); // RL4
    a_short_runs: assert property (@(posedge sys_clk) disable iff (rst)
        !longMode && inhSync && !timerKick && tmr_ff < 38'h10 |=> tmr_ff == $past(tmr_ff) + 38'h1)
        else $error("short timer stopped"); // RL5
    a_boost_force: assert property (@(posedge sys_clk) disable iff (rst)
        ctrlConfigured && boostFnEn && bstActive |=> boostMode_ff) else $error("no boost"); // RL6
    a_cap_select: assert property (@(posedge sys_clk) disable iff (rst)
        !ctrlConfigured && bstSync |=> inCap_ff == CAP_500MA) else $error("cap wrong"); // RL8
    a_stat_charge: assert property (@(posedge sys_clk) disable iff (rst)
        statEn && charging |=> !statOe_n) else $error("indicator not driven"); // RL9
    a_stat_off: assert property (@(posedge sys_clk) disable iff (rst)
        !statEn |=> statOe_n) else $error("indicator driven while off"); // RL11
    sequence s_faultStart;
        faultIn && pulse_ff == 15'h0;
    endsequence
    a_fault_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        s_faultStart |=> pulse_ff == 15'(FAULT_PULSE_CYC)) else $error("pulse length"); // RL10 RL23
    a_term_end: assert property (@(posedge sys_clk) disable iff (rst)
        enable && state_ff == CCL_CV && termEn && currAtTerm |=> state_ff == CCL_DONE)
        else $error("no termination"); // RL13
    a_recharge: assert property (@(posedge sys_clk) disable iff (rst)
        enable && state_ff == CCL_DONE && battBelowRch |=> state_ff == CCL_COND)
        else $error("no recharge"); // RL15
endmodule : ccl_charger_ctrl

// *** testbench/ccl_host_model.sv ***
// Host-side model issuing register writes and timer kicks
`timescale 1ns/100ps
module ccl_host_model (
    input  wire logic       sys_clk,   // System clock
    output logic            regWrStb,  // Write pulse
    output logic            regWrSafe, // Write hits safety limits
    output logic [7:0]      regWrData, // Write data
    output logic            timerKick  // Safety timer reset pulse
);
    initial begin
        {regWrStb, regWrSafe, timerKick} = 3'h0;
        regWrData = 8'h00;
    end

    task automatic wr(input logic safe, input logic [7:0] d);
        @(posedge sys_clk);
        regWrStb  <= 1'b1;
        regWrSafe <= safe;
        regWrData <= d;
        @(posedge sys_clk);
        regWrStb  <= 1'b0;
        regWrData <= ~d;
    endtask : wr

    task automatic kick;
        @(posedge sys_clk) timerKick <= 1'b1;
        @(posedge sys_clk) timerKick <= 1'b0;
    endtask : kick
endmodule : ccl_host_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the charger control logic
`timescale 1ns/100ps
module tb_top
    import ccl_pkg::*;
;
    localparam int LONGC = 200;
    localparam int SHORTC = 50;
    logic sys_clk = 0, rst = 1, linkClk = 0;
    logic inhibitPin, unlockPin, boostPin, boostFnEn, boostActHigh, boostHostCmd;
    logic ctrlConfigured, termEn, longMode, statEn, supplyOk, battAboveShort;
    logic battAtReg, currAtTerm, battBelowRch, tjHot, faultIn;
    logic regWrStb, regWrSafe, timerKick, statOe_n, statOut, inputsHiZ_ff, sleep_ff;
    logic boostMode_ff, chargeRed_ff, timerFault_ff;
    logic [1:0] hostCap, lampLevel, inCap_ff, lampDrive_ff;
    logic [7:0] lampOnMs, lampOffMs, regWrData, safeLimit_ff, lim;
    logic [4:0] chgStatus_ff;
    logic [31:0] seed = 32'h000006EA;
    int n_fail = 0, checks = 0, cycles = 0, lowCnt;

    always #5 sys_clk = ~sys_clk;
    always #40 linkClk = ~linkClk;

    ccl_host_model host (.sys_clk(sys_clk), .regWrStb(regWrStb), .regWrSafe(regWrSafe),
        .regWrData(regWrData), .timerKick(timerKick));

    ccl_charger_ctrl #(.LONG_CYC(LONGC), .SHORT_CYC(SHORTC)) uut (.*);

    function automatic logic [1:0] capFor(input logic pin);
        return pin ? CAP_500MA : CAP_100MA;
    endfunction : capFor

    task automatic rnd;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
    endtask : rnd

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        {unlockPin, boostPin, faultIn, tjHot, supplyOk, battAboveShort} = 6'h00;
        {battAtReg, currAtTerm, battBelowRch, ctrlConfigured, boostFnEn} = 5'h00;
        {boostActHigh, boostHostCmd, termEn, longMode} = 4'h0;
        {inhibitPin, statEn} = 2'h3;
        rnd();
        {hostCap, lampLevel, lampOnMs, lampOffMs} = {2'h0, seed[1:0], seed[15:0]};
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(1);
        chk("statOe_n", 8'h01, statOe_n);
        chk("chgStatus", 8'h01, chgStatus_ff);
        chk("safeLimit", SAFE_LIMIT_RST, safeLimit_ff);
        chk("sleepOrHiZ", 8'h01, sleep_ff | inputsHiZ_ff);
        chk("lampIdle", 8'h00, lampDrive_ff);
        chk("statOut", 8'h00, statOut);
        supplyOk <= 1'b1;
        cyc(5);
        chk("inputsHiZ", 8'h01, inputsHiZ_ff);
        @(posedge sys_clk) faultIn <= 1'b1;
        @(posedge sys_clk) faultIn <= 1'b0;
        lowCnt = 0;
        repeat (13000) begin
            cyc(1);
            if (statOe_n === 1'b0) lowCnt++;
            faultIn <= (lowCnt == 100);
        end
        chk("faultPulse", 8'h01, {7'h00, lowCnt inside {[12798:12803]}});
        for (int i = 0; i < 2; i++) begin
            @(posedge linkClk) boostPin <= i[0];
            cyc(5);
            chk("bootCap", capFor(i[0]), inCap_ff);
        end
        {ctrlConfigured, boostFnEn} <= 2'h3;
        for (int i = 0; i < 4; i++) begin
            @(posedge linkClk) {boostActHigh, boostPin} <= i[1:0];
            cyc(5);
            chk("boostMode", 8'(i[1] == i[0]), boostMode_ff);
        end
        {boostFnEn, boostPin} <= 2'h0;
        rnd();
        hostCap <= {1'b0, seed[0]};
        cyc(5);
        chk("hostCap", {7'h00, seed[0]}, inCap_ff);
        rnd();
        host.wr(1'b1, seed[7:0]);
        cyc(1);
        chk("lockedLow", SAFE_LIMIT_RST, safeLimit_ff);
        unlockPin <= 1'b1;
        cyc(5);
        rnd();
        lim = seed[7:0];
        host.wr(1'b1, lim);
        #1;
        chk("limitWr", lim, safeLimit_ff);
        host.wr(1'b0, ~lim);
        host.wr(1'b1, lim ^ 8'h5A);
        cyc(1);
        chk("limitLock", lim, safeLimit_ff);
        unlockPin <= 1'b0;
        cyc(5);
        chk("limitDflt", SAFE_LIMIT_RST, safeLimit_ff);
        {termEn, longMode, inhibitPin} <= 3'h6;
        host.kick();
        cyc(6);
        chk("cond", 8'h02, chgStatus_ff);
        chk("statLow", 8'h00, statOe_n);
        chk("hiZOff", 8'h00, inputsHiZ_ff);
        tjHot <= 1'b1;
        cyc(3);
        chk("chargeRed", 8'h01, chargeRed_ff);
        tjHot <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            {battAboveShort, battAtReg, currAtTerm} <= 3'h7 << (2 - i);
            cyc(3);
            chk("phase", 8'h04 << i, chgStatus_ff);
        end
        chk("statDone", 8'h01, statOe_n);
        {battAboveShort, battAtReg, currAtTerm, battBelowRch} <= 4'h1;
        cyc(3);
        chk("recharge", 8'h02, chgStatus_ff);
        {battBelowRch, statEn} <= 2'h0;
        cyc(3);
        chk("statOff", 8'h01, statOe_n);
        statEn <= 1'b1;
        host.kick();
        cyc(150);
        inhibitPin <= 1'b1;
        cyc(10);
        inhibitPin <= 1'b0;
        cyc(150);
        chk("longHeld", 8'h00, timerFault_ff);
        cyc(80);
        chk("longExpire", 8'h01, timerFault_ff);
        longMode <= 1'b0;
        host.kick();
        cyc(20);
        inhibitPin <= 1'b1;
        cyc(10);
        inhibitPin <= 1'b0;
        cyc(35);
        chk("shortRun", 8'h01, timerFault_ff);
        supplyOk <= 1'b0;
        cyc(3);
        chk("supplyLoss", 8'h01, sleep_ff | inputsHiZ_ff);
        finish_test();
    end
endmodule : tb_top
